// ==== src/osc_config.sv ====
// Oscillator configuration, stabilization and event flag block with APB register access
`timescale 1ns/1ps
module osc_config
    import osc_cfg_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int WAIT_SHIFT = 0
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // System write protection
    input wire logic wp_unlock_i,
    // Oscillator clocks and analog events
    input wire logic sub_clk_i,
    input wire logic hs_clk_i,
    input wire logic rc_clk_i,
    input wire logic sub_stop_i,
    input wire logic trim_done_i,
    // Subclock oscillator controls
    output logic sub_run_o,
    output logic sub_restart_o,
    output logic stop_det_en_o,
    output logic sub_boost_o,
    output logic [2:0] sub_gate_cap_o,
    output logic [1:0] sub_gain_o,
    // High-speed oscillator controls
    output logic hs_run_o,
    output logic [1:0] hs_type_o,
    output logic [1:0] hs_freq_o,
    output logic [1:0] hs_gain_o,
    // Internal rc oscillator controls
    output logic rc_run_o,
    output logic trim_run_o,
    // Clock gates and interrupt
    output logic sub_clk_gate_o,
    output logic hs_clk_gate_o,
    output logic rc_clk_gate_o,
    output logic irq_o
);
    import osc_cfg_pkg::*;

    // Register fields
    logic restart_en_reg, det_en_reg, boost_en_reg;
    logic [2:0] cap_reg;
    logic [1:0] bgain_reg, ngain_reg, swait_reg;
    logic [1:0] freq_reg, type_reg, inv_reg;
    logic [2:0] hwait_reg;
    logic [15:0] flags_reg, irq_en_reg;
    logic sub_en_reg, hs_en_reg, rc_en_reg, trim_reg;
    // Bus decode
    logic setup, wr, hit;
    logic [7:0] ofs;
    logic [15:0] wdat, rd_next, flag_set;
    // Sampled events
    logic [2:0] stop_sync_reg, trim_sync_reg;
    logic stop_lvl_reg, trim_lvl_reg, stop_rise, trim_rise;
    // Counters
    logic sub_stable, hs_stable, rc_stable, sub_done, hs_done, rc_done;
    logic [WAIT_W-1:0] sub_wait, hs_wait;

    // Wait length scaled down for simulation, never below one clock
    function automatic logic [WAIT_W-1:0] scaled(input logic [WAIT_W-1:0] n);
        logic [WAIT_W-1:0] s;
        s = n >> WAIT_SHIFT;
        return (s == '0) ? WAIT_W'(1) : s;
    endfunction

    // Protected field write qualifier
    function automatic logic prot_ok(input logic w, input logic unlock);
        return w && unlock;
    endfunction

    // ==========================================================
    // APB decode: no wait states, read data captured in setup
    assign setup = psel_i && !penable_i;
    assign wr = psel_i && penable_i && pready_o && pwrite_i;
    assign ofs = 8'(paddr_i);
    assign wdat = pwdata_i[15:0];
    assign hit = (ofs == SUB_CTRL_OFS) || (ofs == HS_CTRL_OFS) || (ofs == FLAGS_OFS) ||
                 (ofs == OSC_EN_OFS) || (ofs == TRIM_OFS) || (ofs == IRQ_EN_OFS) || (ofs == STATUS_OFS);

    // Read mux; reserved bits read as zero
    always_comb begin
        rd_next = 16'h0000;
        unique case (ofs)
            SUB_CTRL_OFS: begin
                rd_next[SUB_RESTART_BIT] = restart_en_reg;
                rd_next[SUB_DET_BIT] = det_en_reg;
                rd_next[SUB_BOOST_BIT] = boost_en_reg;
                rd_next[SUB_CAP_LSB +: 3] = cap_reg;
                rd_next[SUB_BGAIN_LSB +: 2] = bgain_reg;
                rd_next[SUB_NGAIN_LSB +: 2] = ngain_reg;
                rd_next[SUB_WAIT_LSB +: 2] = swait_reg;
            end
            HS_CTRL_OFS: begin
                rd_next[HS_FREQ_LSB +: 2] = freq_reg;
                rd_next[HS_TYPE_LSB +: 2] = type_reg;
                rd_next[HS_INV_LSB +: 2] = inv_reg;
                rd_next[HS_WAIT_LSB +: 3] = hwait_reg;
            end
            FLAGS_OFS: rd_next = flags_reg & FLAG_MASK;
            OSC_EN_OFS: begin
                rd_next[RC_BIT] = rc_en_reg;
                rd_next[SUB_BIT] = sub_en_reg;
                rd_next[HS_BIT] = hs_en_reg;
            end
            TRIM_OFS: rd_next[TRIM_BIT] = trim_reg;
            IRQ_EN_OFS: rd_next = irq_en_reg;
            STATUS_OFS: begin
                rd_next[RC_BIT] = rc_stable;
                rd_next[SUB_BIT] = sub_stable;
                rd_next[HS_BIT] = hs_stable;
                rd_next[TRIM_BIT] = trim_reg;
                rd_next[STOP_BIT] = stop_lvl_reg;
            end
            default: rd_next = 16'h0000;
        endcase
    end

    // Bus answer flops
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup && !hit;
            if (setup) begin
                prdata_o <= {16'h0000, rd_next};
            end
        end
    end

    // ==========================================================
    // Protected configuration; writes while locked are dropped
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            restart_en_reg <= SUB_RESTART_RST;
            det_en_reg <= SUB_DET_RST;
            boost_en_reg <= SUB_BOOST_RST;
            cap_reg <= SUB_CAP_RST;
            bgain_reg <= SUB_BGAIN_RST;
            ngain_reg <= SUB_NGAIN_RST;
            swait_reg <= SUB_WAIT_RST;
            freq_reg <= HS_FREQ_RST;
            type_reg <= HS_TYPE_RST;
            inv_reg <= HS_INV_RST;
            hwait_reg <= HS_WAIT_RST;
        end else begin
            if (prot_ok(wr && ofs == SUB_CTRL_OFS, wp_unlock_i)) begin
                restart_en_reg <= wdat[SUB_RESTART_BIT];
                det_en_reg <= wdat[SUB_DET_BIT];
                boost_en_reg <= wdat[SUB_BOOST_BIT];
                cap_reg <= wdat[SUB_CAP_LSB +: 3];
                bgain_reg <= wdat[SUB_BGAIN_LSB +: 2];
                ngain_reg <= wdat[SUB_NGAIN_LSB +: 2];
                swait_reg <= wdat[SUB_WAIT_LSB +: 2];
            end
            if (prot_ok(wr && ofs == HS_CTRL_OFS, wp_unlock_i)) begin
                freq_reg <= wdat[HS_FREQ_LSB +: 2];
                type_reg <= wdat[HS_TYPE_LSB +: 2];
                inv_reg <= wdat[HS_INV_LSB +: 2];
                hwait_reg <= wdat[HS_WAIT_LSB +: 3];
            end
        end
    end

    // Enables, trim start and interrupt enables
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sub_en_reg <= 1'b0;
            hs_en_reg <= 1'b0;
            rc_en_reg <= RC_EN_RST;
            trim_reg <= 1'b0;
            irq_en_reg <= 16'h0000;
        end else begin
            if (wr && ofs == OSC_EN_OFS) begin
                rc_en_reg <= wdat[RC_BIT];
                sub_en_reg <= wdat[SUB_BIT];
                hs_en_reg <= wdat[HS_BIT];
            end
            // Completion wins over a start in the same cycle
            if (trim_rise) begin
                trim_reg <= 1'b0;
            end else if (prot_ok(wr && ofs == TRIM_OFS, wp_unlock_i)) begin
                trim_reg <= wdat[TRIM_BIT];
            end
            if (wr && ofs == IRQ_EN_OFS) begin
                irq_en_reg <= wdat & FLAG_MASK;
            end
        end
    end

    // ==========================================================
    // Event inputs: three flops, accepted once stages two and three agree
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stop_sync_reg <= 3'h0;
            trim_sync_reg <= 3'h0;
            stop_lvl_reg <= 1'b0;
            trim_lvl_reg <= 1'b0;
        end else begin
            stop_sync_reg <= {stop_sync_reg[1:0], sub_stop_i};
            trim_sync_reg <= {trim_sync_reg[1:0], trim_done_i};
            if (stop_sync_reg[1] == stop_sync_reg[2]) begin
                stop_lvl_reg <= stop_sync_reg[2];
            end
            if (trim_sync_reg[1] == trim_sync_reg[2]) begin
                trim_lvl_reg <= trim_sync_reg[2];
            end
        end
    end
    // Stop events are ignored while the detector is off
    assign stop_rise = det_en_reg && !stop_lvl_reg && stop_sync_reg[1] && stop_sync_reg[2];
    assign trim_rise = trim_reg && !trim_lvl_reg && trim_sync_reg[1] && trim_sync_reg[2];

    // ==========================================================
    // Stabilization counters, one per source
    assign sub_wait = scaled(SUB_WAIT_BASE << (2 * ((swait_reg == 2'h0) ? 0 : swait_reg - 2'h1)));
    assign hs_wait = scaled(HS_WAIT_BASE << (2 * hwait_reg));

    stab_counter #(.WAIT_W(WAIT_W), .START_STABLE(1'b0)) u_sub_cnt (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .en_i(sub_en_reg), .restart_i(sub_restart_o),
        .wait_i(sub_wait), .osc_clk_i(sub_clk_i), .stable_o(sub_stable), .done_o(sub_done)
    );
    stab_counter #(.WAIT_W(WAIT_W), .START_STABLE(1'b0)) u_hs_cnt (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .en_i(hs_en_reg), .restart_i(1'b0),
        .wait_i(hs_wait), .osc_clk_i(hs_clk_i), .stable_o(hs_stable), .done_o(hs_done)
    );
    // Rc source is already running at reset, so it starts stable with no event
    stab_counter #(.WAIT_W(WAIT_W), .START_STABLE(1'b1)) u_rc_cnt (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .en_i(rc_en_reg), .restart_i(1'b0),
        .wait_i(scaled(RC_WAIT_CLKS)), .osc_clk_i(rc_clk_i), .stable_o(rc_stable), .done_o(rc_done)
    );

    // ==========================================================
    // Event flags: a set in the clearing cycle wins
    always_comb begin
        flag_set = 16'h0000;
        flag_set[STOP_BIT] = stop_rise;
        flag_set[TRIM_BIT] = trim_rise;
        flag_set[HS_BIT] = hs_done;
        flag_set[SUB_BIT] = sub_done;
        flag_set[RC_BIT] = rc_done;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_reg <= 16'h0000;
        end else begin
            flags_reg <= ((flags_reg & ~((wr && ofs == FLAGS_OFS) ? wdat : 16'h0000)) | flag_set) & FLAG_MASK;
        end
    end

    // ==========================================================
    // Analog control outputs, all registered
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sub_run_o <= 1'b0;
            sub_restart_o <= 1'b0;
            stop_det_en_o <= SUB_DET_RST;
            sub_boost_o <= 1'b0;
            sub_gate_cap_o <= SUB_CAP_RST;
            sub_gain_o <= SUB_NGAIN_RST;
            hs_run_o <= 1'b0;
            hs_type_o <= HS_TYPE_RST;
            hs_freq_o <= HS_FREQ_RST;
            hs_gain_o <= 2'h0;
            rc_run_o <= RC_EN_RST;
            trim_run_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            sub_run_o <= sub_en_reg;
            sub_restart_o <= stop_rise && restart_en_reg && sub_en_reg;
            stop_det_en_o <= det_en_reg;
            sub_boost_o <= boost_en_reg && sub_en_reg && !sub_stable;
            sub_gate_cap_o <= cap_reg;
            sub_gain_o <= (boost_en_reg && !sub_stable) ? bgain_reg : ngain_reg;
            hs_run_o <= hs_en_reg;
            hs_type_o <= type_reg;
            hs_freq_o <= freq_reg;
            hs_gain_o <= (type_reg == HS_TYPE_XTAL) ? inv_reg : 2'h0;
            rc_run_o <= rc_en_reg;
            trim_run_o <= trim_reg;
            irq_o <= |(flags_reg & irq_en_reg);
        end
    end
    // Gates come straight from the counters' own flops
    assign sub_clk_gate_o = sub_stable;
    assign hs_clk_gate_o = hs_stable;
    assign rc_clk_gate_o = rc_stable;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    restart_on_stop_a: assert property (stop_rise && restart_en_reg && sub_en_reg |=> sub_restart_o)
        else $error("stop with restart enabled did not restart subclock");
    no_restart_off_a: assert property (!restart_en_reg |=> !sub_restart_o)
        else $error("restart issued while restart disabled");
    stop_needs_det_a: assert property ($rose(flags_reg[STOP_BIT]) |-> $past(det_en_reg))
        else $error("stop flag set with detector off");
    gain_select_a: assert property (sub_boost_o |-> sub_gain_o == $past(bgain_reg))
        else $error("boost gain not applied during boost");
    hs_gain_gate_a: assert property ($past(type_reg) != HS_TYPE_XTAL |-> hs_gain_o == 2'h0)
        else $error("inverter gain driven for non-crystal type");
    stable_flag_set_a: assert property (hs_done |=> flags_reg[HS_BIT])
        else $error("high-speed stable event lost");
    w1c_clear_a: assert property (wr && ofs == FLAGS_OFS && wdat[SUB_BIT] && !sub_done
                                  |=> !flags_reg[SUB_BIT])
        else $error("write one did not clear flag");
    reserved_zero_a: assert property ((flags_reg & ~FLAG_MASK) == 16'h0000)
        else $error("reserved flag bit set");
    locked_hold_a: assert property (wr && !wp_unlock_i |=> $stable(swait_reg) && $stable(hwait_reg))
        else $error("protected field changed while locked");
    irq_gate_a: assert property ((flags_reg & irq_en_reg) == 16'h0000 |=> !irq_o)
        else $error("interrupt raised without enabled flag");
endmodule // osc_config

// ==== common/osc_cfg_pkg.sv ====
// Package of register map, field layout and timing constants for the oscillator configuration block
package osc_cfg_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] SUB_CTRL_OFS = 8'h00;
    localparam logic [7:0] HS_CTRL_OFS = 8'h04;
    localparam logic [7:0] FLAGS_OFS = 8'h08;
    localparam logic [7:0] OSC_EN_OFS = 8'h0C;
    localparam logic [7:0] TRIM_OFS = 8'h10;
    localparam logic [7:0] IRQ_EN_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    // ==========================================================
    // Subclock control fields
    localparam int SUB_RESTART_BIT = 14;
    localparam int SUB_DET_BIT = 13;
    localparam int SUB_BOOST_BIT = 12;
    localparam int SUB_CAP_LSB = 8;
    localparam int SUB_BGAIN_LSB = 6;
    localparam int SUB_NGAIN_LSB = 4;
    localparam int SUB_WAIT_LSB = 0;
    localparam logic SUB_RESTART_RST = 1'b1;
    localparam logic SUB_DET_RST = 1'b0;
    localparam logic SUB_BOOST_RST = 1'b1;
    localparam logic [2:0] SUB_CAP_RST = 3'h0;
    localparam logic [1:0] SUB_BGAIN_RST = 2'h2;
    localparam logic [1:0] SUB_NGAIN_RST = 2'h1;
    localparam logic [1:0] SUB_WAIT_RST = 2'h2;
    // ==========================================================
    // High-speed control fields
    localparam int HS_FREQ_LSB = 10;
    localparam int HS_TYPE_LSB = 8;
    localparam int HS_INV_LSB = 4;
    localparam int HS_WAIT_LSB = 0;
    localparam logic [1:0] HS_FREQ_RST = 2'h3;
    localparam logic [1:0] HS_TYPE_RST = 2'h0;
    localparam logic [1:0] HS_INV_RST = 2'h1;
    localparam logic [2:0] HS_WAIT_RST = 3'h0;
    // Oscillator types
    localparam logic [1:0] HS_TYPE_INTERNAL = 2'h0;
    localparam logic [1:0] HS_TYPE_CR = 2'h1;
    localparam logic [1:0] HS_TYPE_XTAL = 2'h2;
    // ==========================================================
    // Flag, enable and status bit positions
    localparam int RC_BIT = 0;
    localparam int SUB_BIT = 1;
    localparam int HS_BIT = 2;
    localparam int TRIM_BIT = 4;
    localparam int STOP_BIT = 5;
    localparam logic [15:0] FLAG_MASK = 16'h0037;
    localparam logic RC_EN_RST = 1'b1;
    // ==========================================================
    // Stabilization wait counts in oscillator clocks
    localparam int WAIT_W = 17;
    localparam logic [WAIT_W-1:0] SUB_WAIT_BASE = 17'h01000;
    localparam logic [WAIT_W-1:0] HS_WAIT_BASE = 17'h00004;
    localparam logic [WAIT_W-1:0] RC_WAIT_CLKS = 17'h00040;
endpackage

// ==== src/stab_counter.sv ====
// Stabilization wait counter driven by sampled edges of one oscillator clock
`timescale 1ns/1ps
module stab_counter #(
    parameter int WAIT_W = 17,
    parameter bit START_STABLE = 1'b0
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Control
    input wire logic en_i,
    input wire logic restart_i,
    input wire logic [WAIT_W-1:0] wait_i,
    input wire logic osc_clk_i,
    // Result
    output logic stable_o,
    output logic done_o
);
    logic [2:0] sync_reg;
    logic lvl_reg;
    logic rise;
    logic [WAIT_W-1:0] cnt_reg;

    // ==========================================================
    // Three-stage sampler; a level is accepted once stages two and three agree
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_reg <= 3'h0;
            lvl_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], osc_clk_i};
            if (sync_reg[1] == sync_reg[2]) begin
                lvl_reg <= sync_reg[2];
            end
        end
    end
    assign rise = !lvl_reg && sync_reg[1] && sync_reg[2];

    // ==========================================================
    // Count oscillator edges from enable until the programmed wait is reached
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= '0;
            stable_o <= START_STABLE;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (!en_i || restart_i) begin
                cnt_reg <= '0;
                stable_o <= 1'b0;
            end else if (!stable_o && rise) begin
                if (cnt_reg + WAIT_W'(1) >= wait_i) begin
                    stable_o <= 1'b1;
                    done_o <= 1'b1;
                end
                cnt_reg <= cnt_reg + WAIT_W'(1);
            end
        end
    end
endmodule // stab_counter

// ==== dv/testbench.sv ====
// Self-checking testbench for the oscillator configuration block
`timescale 1ns/1ps
module testbench
    import osc_cfg_pkg::*;
;
    // ==========================================================
    // Stimulus and observed signals
    localparam int SH = 8;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wp = 1'b0;
    logic sub_stop = 1'b0, trim_done = 1'b0, slverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, dummy;
    logic [2:0] oclk = 3'h0;
    wire [31:0] prdata;
    wire pready, pslverr, sub_run, sub_restart, det_en, boost, hs_run, rc_run, trim_run, irq;
    wire [2:0] cap, gates;
    wire [1:0] sgain, hs_type, hs_freq, hs_gain;
    int errors = 0, n_checks = 0, cyc = 0, nrst = 0;

    // Shortened waits keep the longest count at 256 oscillator edges
    osc_config #(.ADDR_W(8), .WAIT_SHIFT(SH)) uut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .wp_unlock_i(wp), .sub_clk_i(oclk[0]), .hs_clk_i(oclk[1]), .rc_clk_i(oclk[2]),
        .sub_stop_i(sub_stop), .trim_done_i(trim_done), .sub_run_o(sub_run), .sub_restart_o(sub_restart),
        .stop_det_en_o(det_en), .sub_boost_o(boost), .sub_gate_cap_o(cap), .sub_gain_o(sgain),
        .hs_run_o(hs_run), .hs_type_o(hs_type), .hs_freq_o(hs_freq), .hs_gain_o(hs_gain),
        .rc_run_o(rc_run), .trim_run_o(trim_run), .sub_clk_gate_o(gates[0]), .hs_clk_gate_o(gates[1]),
        .rc_clk_gate_o(gates[2]), .irq_o(irq)
    );

    // ==========================================================
    // Clock, restart pulse counter and hang guard
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    // Restart is a one-cycle pulse, so it is counted rather than sampled
    always @(posedge mclk_i) begin
        if (sub_restart === 1'b1) nrst++;
        cyc++;
        if (cyc == 30000) begin
            errors++;
            stop_test();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; two idle edges after it let registered outputs settle before checks
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        // Answer and read data are taken at the edge that samples pready high
        do begin
            @(posedge mclk_i);
        end while (pready !== 1'b1);
        q = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check($sformatf("reg_%h", a), q, e);
    endtask

    // Pulses one oscillator clock; the half period spans the input sampler
    task automatic osc(input int sel, input int n);
        repeat (n) begin
            oclk[sel] <= 1'b1;
            repeat (4) @(posedge mclk_i);
            oclk[sel] <= 1'b0;
            repeat (4) @(posedge mclk_i);
        end
    endtask

    // Gate must stay shut one edge short of the count and open on it
    task automatic stab(input int sel, input int n, input int fb);
        logic [31:0] q;
        osc(sel, n - 1);
        check("gate_early", gates[sel], 1'b0);
        osc(sel, 1);
        check("gate_done", gates[sel], 1'b1);
        apb(1'b0, FLAGS_OFS, 32'h0, q);
        check("stable_flag", q[fb], 1'b1);
    endtask

    function automatic int sub_wait(input int c);
        return (4096 << (2 * (c - 1))) >> SH;
    endfunction

    function automatic int hs_wait(input int w);
        int n;
        n = (4 << (2 * w)) >> SH;
        return (n < 1) ? 1 : n;
    endfunction

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] sv, hv;
        int c, w, f, g, t, gb, gn, cp;
        void'($urandom(32'h1A04));
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        rd(SUB_CTRL_OFS, 32'h5092);
        rd(HS_CTRL_OFS, 32'h0C10);
        rd(FLAGS_OFS, 32'h0);
        check("rc_gate", gates[2], 1'b1);
        // Locked writes must leave the fields alone
        wr(SUB_CTRL_OFS, $urandom());
        rd(SUB_CTRL_OFS, 32'h5092);
        apb(1'b0, 8'h1C, 32'h0, dummy);
        check("unmapped", {dummy[30:0], slverr}, 32'h1);
        wp <= 1'b1;
        // Every type code, ending on crystal for the wait test
        for (int k = 0; k < 4; k++) begin
            t = (k + 3) % 4;
            f = $urandom_range(3);
            g = $urandom_range(3);
            w = $urandom_range(7);
            hv = (f << 10) | (t << 8) | (g << 4) | w;
            wr(HS_CTRL_OFS, hv | 32'hF0C8);
            rd(HS_CTRL_OFS, hv);
            check("hs_type", hs_type, t);
            check("hs_freq", hs_freq, f);
            check("hs_gain", hs_gain, (t == 2) ? g : 0);
        end
        gn = $urandom_range(3);
        gb = $urandom_range(3, gn);
        cp = $urandom_range(7);
        c = $urandom_range(3, 1);
        sv = 32'h5000 | (cp << 8) | (gb << 6) | (gn << 4) | c;
        wr(SUB_CTRL_OFS, sv);
        check("gate_cap", cap, cp);
        wr(OSC_EN_OFS, 32'h7);
        check("run", {rc_run, hs_run, sub_run}, 3'h7);
        check("boost_on", {boost, sgain}, {1'b1, gb[1:0]});
        stab(0, sub_wait(c), 1);
        check("boost_off", {boost, sgain}, {1'b0, gn[1:0]});
        stab(1, hs_wait(w), 2);
        wr(OSC_EN_OFS, 32'h6);
        check("rc_stop", {rc_run, gates[2]}, 2'h0);
        wr(OSC_EN_OFS, 32'h7);
        stab(2, 1, 0);
        wr(FLAGS_OFS, 32'h0);
        rd(FLAGS_OFS, 32'h7);
        wr(FLAGS_OFS, 32'hFFFF);
        rd(FLAGS_OFS, 32'h0);
        // Stop with restart enabled, then with restart disabled
        wr(SUB_CTRL_OFS, sv | 32'h2000);
        check("det_en", det_en, 1'b1);
        sub_stop <= 1'b1;
        repeat (8) @(posedge mclk_i);
        check("restarts", nrst, 1);
        check("sub_regate", gates[0], 1'b0);
        rd(FLAGS_OFS, 32'h20);
        sub_stop <= 1'b0;
        wr(SUB_CTRL_OFS, (sv & 32'hBFFF) | 32'h2000);
        sub_stop <= 1'b1;
        repeat (8) @(posedge mclk_i);
        check("no_restart", nrst, 1);
        check("irq_masked", irq, 1'b0);
        wr(IRQ_EN_OFS, 32'h20);
        repeat (2) @(posedge mclk_i);
        check("irq_on", irq, 1'b1);
        wr(FLAGS_OFS, 32'h20);
        repeat (2) @(posedge mclk_i);
        check("irq_off", irq, 1'b0);
        // Trimming ends on the done input and raises its flag
        wr(TRIM_OFS, 32'h10);
        check("trim_run", trim_run, 1'b1);
        trim_done <= 1'b1;
        repeat (4) @(posedge mclk_i);
        trim_done <= 1'b0;
        repeat (4) @(posedge mclk_i);
        check("trim_end", trim_run, 1'b0);
        rd(FLAGS_OFS, 32'h10);
        stop_test();
    end
endmodule // testbench
